// >>> hw/pdm_mic_decimator.sv
// PDM microphone decimator: clock generator, per-channel filters and FIFOs
// Assumes a classic Wishbone master and microphones on shared data pairs
// What this block does
// - Turn 1-bit PDM into 16-bit PCM
// - Chain aims at low ripple, high stopband
// - Shared configuration, per-channel enable bits
// - One data input per microphone pair
// - Per-channel CIC, half-band, FIR, DC remover
// - Low-pass audio band at default rate
// - One shared microphone clock, never gated per mic
// - Timing unit sequences decimation and stage starts
// - Channel output into FIFO, read through port
// - All enabled FIFOs over watermark: irq/DMA
// - Hardware voice activity detector watches audio
// - Three-bit quality code, medium by default
// - Eight channels at 48 or 44.1 kHz
`include "pdm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pdm_mic_decimator
	import pdm_pkg::*;
#(
	parameter int NCH   = 8,
	parameter int DEPTH = 8,
	parameter int CW    = 26
) (
	input  wire logic             MCLK_IN,
	input  wire logic             RST_N_IN,
	input  wire logic [NCH/2-1:0] PDM_DATA_IN,
	output logic                  PDM_CLK_OUT,
	input  wire logic             WB_CYC_IN,
	input  wire logic             WB_STB_IN,
	input  wire logic             WB_WE_IN,
	input  wire logic [7:0]       WB_ADR_IN,
	input  wire logic [3:0]       WB_SEL_IN,
	input  wire logic [31:0]      WB_DAT_IN,
	output logic [31:0]           WB_DAT_OUT,
	output logic                  WB_ACK_OUT,
	output logic                  IRQ_OUT,
	output logic                  DMA_REQ_OUT
);
	localparam int AW = $clog2(DEPTH);
	localparam int FW = $clog2(DEPTH + 1);

	pdm_wb_req_s             req;
	pdm_ctrl_s               cfg;
	pdm_seq_e                seq;
	logic [31:0]             ctrl;
	logic [NCH-1:0]          chan_en;
	logic [3:0]              wmark;
	logic [2:0]              status;
	logic [2:0]              mask;
	logic [15:0]             vad_thr;
	logic [31:0]             rd_mux;
	logic [31:0]             fill_pack;
	logic                    taken;
	logic                    wr_take;
	logic                    is_sample;
	logic [3:0]              ch_off;
	logic [NCH-1:0]          pop_vec;
	logic [NCH-1:0]          ovf_vec;
	logic [NCH-1:0]          over_vec;
	logic                    wm_cond;
	logic                    vad_evt;
	logic [2:0]              st_set;
	logic [2:0]              st_clr;
	logic [NCH/2-1:0]        pdm_s1;
	logic [NCH/2-1:0]        pdm_s2;
	logic [7:0]              div_cnt;
	logic                    pclk;
	logic                    rise_stb;
	logic                    fall_stb;
	logic [7:0]              dec_cnt;
	logic                    cic_stb;
	logic                    hb_phase;
	logic                    fir_bypass;
	logic [FW-1:0]           fifo_cnt [NCH];
	logic [15:0]             fifo_head [NCH];
	logic signed [15:0]      chan_pcm [NCH];

	assign req = '{cyc: WB_CYC_IN, stb: WB_STB_IN, we: WB_WE_IN,
		adr: WB_ADR_IN, sel: WB_SEL_IN, dat: WB_DAT_IN};
	assign cfg = '{enable: ctrl[`PDM_CTRL_EN_BIT],
		dma_sel: ctrl[`PDM_CTRL_DMA_BIT],
		quality: pdm_quality_e'(ctrl[`PDM_CTRL_QUAL_LSB +: 3]),
		rate: ctrl[`PDM_CTRL_RATE_LSB +: 8],
		div: ctrl[`PDM_CTRL_DIV_LSB +: 8],
		shift: ctrl[`PDM_CTRL_SHIFT_LSB +: 5]};
	// Low and very-low quality skip the FIR stage to save power
	assign fir_bypass = (cfg.quality == quality_low) ||
		(cfg.quality == quality_very_low_0) ||
		(cfg.quality == quality_very_low_1) ||
		(cfg.quality == quality_very_low_2);

	function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic signed [19:0] sat20(input logic signed [CW-1:0] v);
		if (v > CW'(20'sh7FFFF)) begin
			return 20'sh7FFFF;
		end else if (v < CW'(20'sh80000)) begin
			return 20'sh80000;
		end
		return v[19:0];
	endfunction

	function automatic logic signed [15:0] sat16(input logic signed [23:0] v);
		if (v > 24'sh007FFF) begin
			return 16'sh7FFF;
		end else if (v < -24'sh008000) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction

	// Synchroniser for the microphone data pairs
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pdm_s1 <= '0;
			pdm_s2 <= '0;
		end else begin
			pdm_s1 <= PDM_DATA_IN;
			pdm_s2 <= pdm_s1;
		end
	end

	// One microphone clock for every microphone; only the global enable stops it
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			div_cnt  <= 8'h00;
			pclk     <= 1'b0;
			rise_stb <= 1'b0;
			fall_stb <= 1'b0;
		end else begin
			rise_stb <= 1'b0;
			fall_stb <= 1'b0;
			if (!cfg.enable) begin
				div_cnt <= 8'h00;
				pclk    <= 1'b0;
			end else if (div_cnt + 8'h01 >= cfg.div) begin
				div_cnt  <= 8'h00;
				pclk     <= !pclk;
				rise_stb <= !pclk;
				fall_stb <= pclk;
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
		end
	end
	assign PDM_CLK_OUT = pclk;

	// Decimation counter in microphone clock periods
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			dec_cnt <= 8'h00;
			cic_stb <= 1'b0;
		end else begin
			cic_stb <= 1'b0;
			if (!cfg.enable) begin
				dec_cnt <= 8'h00;
			end else if (fall_stb) begin
				if (dec_cnt + 8'h01 >= cfg.rate) begin
					dec_cnt <= 8'h00;
					cic_stb <= 1'b1;
				end else begin
					dec_cnt <= dec_cnt + 8'h01;
				end
			end
		end
	end

	// Stage sequencer: half-band decimates by two, so FIR runs every other
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			seq      <= SEQ_IDLE;
			hb_phase <= 1'b0;
		end else begin
			unique case (seq)
				SEQ_IDLE: begin
					if (cic_stb) begin
						seq <= SEQ_COMB;
					end
				end
				SEQ_COMB: seq <= SEQ_HB;
				SEQ_HB: begin
					hb_phase <= !hb_phase;
					seq      <= hb_phase ? SEQ_FIR : SEQ_IDLE;
				end
				SEQ_FIR: seq <= SEQ_DC;
				SEQ_DC: seq <= SEQ_PUSH;
				SEQ_PUSH: seq <= SEQ_IDLE;
			endcase
		end
	end

	for (genvar c = 0; c < NCH; c++) begin : g_chan
		// Even channel latched at rising edge, odd one at falling edge
		localparam bit ODD = (c % 2) == 1;
		logic                 in_bit;
		logic                 in_stb;
		logic                 run;
		logic signed [CW-1:0] i1, i2, i3, d1, d2, d3, c1, c2, c3;
		logic signed [19:0]   cic_s, h1, h2, hb_s, f1, f2, f3, fir_s;
		logic signed [19:0]   dc_x;
		logic signed [23:0]   dc_y;
		logic signed [23:0]   hb_sum;
		logic signed [23:0]   fir_sum;
		logic [15:0]          mem [DEPTH];
		logic [AW-1:0]        wp;
		logic [AW-1:0]        rp;
		logic                 push;

		assign in_bit = pdm_s2[c/2];
		assign in_stb = ODD ? fall_stb : rise_stb;
		assign run = cfg.enable && chan_en[c];
		assign c1 = i3 - d1;
		assign c2 = c1 - d2;
		assign c3 = c2 - d3;
		assign hb_sum = 24'(cic_s) + 24'(h1) + 24'(h1) + 24'(h2);
		assign fir_sum = 24'(hb_s) + 24'(f1) + 24'(f1) + 24'(f1) +
			24'(f2) + 24'(f2) + 24'(f2) + 24'(f3);

		// Third-order CIC integrators at the microphone bit rate
		always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
			if (!RST_N_IN) begin
				i1 <= '0;
				i2 <= '0;
				i3 <= '0;
			end else if (run && in_stb) begin
				i1 <= in_bit ? i1 + CW'(1) : i1 - CW'(1);
				i2 <= i2 + i1;
				i3 <= i3 + i2;
			end
		end

		// Comb, half-band, FIR and DC remover at decimated rates
		always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
			if (!RST_N_IN) begin
				{d1, d2, d3} <= '0;
				{cic_s, h1, h2, hb_s} <= '0;
				{f1, f2, f3, fir_s, dc_x} <= '0;
				dc_y <= '0;
			end else if (run) begin
				if (seq == SEQ_COMB) begin
					d1    <= i3;
					d2    <= c1;
					d3    <= c2;
					cic_s <= sat20(c3 >>> cfg.shift);
				end
				if (seq == SEQ_HB) begin
					h1   <= cic_s;
					h2   <= h1;
					hb_s <= hb_sum[21:2];
				end
				if (seq == SEQ_FIR) begin
					f1    <= hb_s;
					f2    <= f1;
					f3    <= f2;
					fir_s <= fir_bypass ? hb_s : fir_sum[22:3];
				end
				if (seq == SEQ_DC) begin
					dc_x <= fir_s;
					dc_y <= 24'(fir_s) - 24'(dc_x) + dc_y -
						(dc_y >>> `PDM_DC_SHIFT);
				end
			end
		end
		assign chan_pcm[c] = sat16(dc_y);

		// Per-channel FIFO; a full FIFO drops the new sample and flags it
		assign push = run && (seq == SEQ_PUSH);
		assign ovf_vec[c] = push && (fifo_cnt[c] == FW'(DEPTH));
		always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
			if (!RST_N_IN) begin
				wp          <= '0;
				rp          <= '0;
				fifo_cnt[c] <= '0;
			end else if (!chan_en[c]) begin
				wp          <= '0;
				rp          <= '0;
				fifo_cnt[c] <= '0;
			end else begin
				if (push && !ovf_vec[c]) begin
					mem[wp] <= chan_pcm[c];
					wp      <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
				end
				if (pop_vec[c]) begin
					rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
				end
				if ((push && !ovf_vec[c]) && !pop_vec[c]) begin
					fifo_cnt[c] <= fifo_cnt[c] + FW'(1);
				end else if (pop_vec[c] && !(push && !ovf_vec[c])) begin
					fifo_cnt[c] <= fifo_cnt[c] - FW'(1);
				end
			end
		end
		assign fifo_head[c] = mem[rp];
		assign over_vec[c] = !chan_en[c] || (8'(fifo_cnt[c]) > 8'(wmark));
		assign fill_pack[4*c +: 4] = 4'(fifo_cnt[c]);
	end
	if (NCH < 8) begin : g_fill_pad
		assign fill_pack[31:4*NCH] = '0;
	end

	// Bus decode; the answer comes one cycle after the request
	assign taken = req.cyc && req.stb && !WB_ACK_OUT;
	assign wr_take = taken && req.we;
	assign ch_off = req.adr[5:2];
	assign is_sample = (req.adr[7:6] == `PDM_OFF_SAMPLE_BASE >> 6) &&
		(req.adr[1:0] == 2'h0) && (32'(ch_off) < NCH);

	always_comb begin
		pop_vec = '0;
		for (int c = 0; c < NCH; c++) begin
			if (taken && !req.we && is_sample && (32'(ch_off) == c) &&
				(fifo_cnt[c] != '0)) begin
				pop_vec[c] = 1'b1;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (is_sample) begin
			for (int c = 0; c < NCH; c++) begin
				if ((32'(ch_off) == c) && (fifo_cnt[c] != '0)) begin
					rd_mux = {{16{fifo_head[c][15]}}, fifo_head[c]};
				end
			end
		end else begin
			case (req.adr)
				`PDM_OFF_CTRL:    rd_mux = ctrl;
				`PDM_OFF_CHAN_EN: rd_mux = 32'(chan_en);
				`PDM_OFF_WMARK:   rd_mux = 32'(wmark);
				`PDM_OFF_STATUS:  rd_mux = 32'(status);
				`PDM_OFF_MASK:    rd_mux = 32'(mask);
				`PDM_OFF_VAD_THR: rd_mux = 32'(vad_thr);
				`PDM_OFF_FILL:    rd_mux = fill_pack;
				default:          rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_DAT_OUT <= 32'h0000_0000;
		end else begin
			WB_ACK_OUT <= taken;
			if (taken && !req.we) begin
				WB_DAT_OUT <= rd_mux;
			end
		end
	end

	// Configuration registers, byte lanes honoured
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl    <= `PDM_CTRL_RST;
			chan_en <= `PDM_CHAN_EN_RST;
			wmark   <= `PDM_WMARK_RST;
			mask    <= `PDM_MASK_RST;
			vad_thr <= `PDM_VAD_THR_RST;
		end else if (wr_take) begin
			case (req.adr)
				`PDM_OFF_CTRL:    ctrl <= merge_sel(ctrl, req.dat, req.sel);
				`PDM_OFF_CHAN_EN: chan_en <= NCH'(merge_sel(32'(chan_en),
					req.dat, req.sel));
				`PDM_OFF_WMARK:   wmark <= 4'(merge_sel(32'(wmark),
					req.dat, req.sel));
				`PDM_OFF_MASK:    mask <= 3'(merge_sel(32'(mask),
					req.dat, req.sel));
				`PDM_OFF_VAD_THR: vad_thr <= 16'(merge_sel(32'(vad_thr),
					req.dat, req.sel));
				default: ;
			endcase
		end
	end

	// Watermark over every enabled channel; disabled channels do not hold it back
	assign wm_cond = cfg.enable && (chan_en != '0) && (&over_vec);
	// Simple energy detector on channel 0, checked as each sample is stored
	assign vad_evt = cfg.enable && chan_en[0] && (seq == SEQ_PUSH) &&
		((chan_pcm[0][15] ? 16'(-chan_pcm[0]) : chan_pcm[0]) > vad_thr);
	assign st_set = {vad_evt, |ovf_vec, wm_cond && !cfg.dma_sel};
	assign st_clr = (wr_take && (req.adr == `PDM_OFF_STATUS) && req.sel[0]) ?
		req.dat[2:0] : 3'h0;

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			status      <= 3'h0;
			IRQ_OUT     <= 1'b0;
			DMA_REQ_OUT <= 1'b0;
		end else begin
			status      <= (status & ~st_clr) | st_set;
			IRQ_OUT     <= |(status & mask);
			DMA_REQ_OUT <= wm_cond && cfg.dma_sel;
		end
	end
	// Eight channels by default; the output rate is set by divider and rate
	// fields, so 44.1 kHz is a software choice of those two
endmodule : pdm_mic_decimator
`default_nettype wire

// >>> hw/pdm_regs.svh
// Register offsets, field positions, reset values of the PDM decimator
// Assumes byte addressing on a classic Wishbone bus with 32-bit data
`ifndef PDM_REGS_SVH
`define PDM_REGS_SVH
`define PDM_OFF_CTRL        8'h00
`define PDM_OFF_CHAN_EN     8'h04
`define PDM_OFF_WMARK       8'h08
`define PDM_OFF_STATUS      8'h0C
`define PDM_OFF_MASK        8'h10
`define PDM_OFF_VAD_THR     8'h14
`define PDM_OFF_FILL        8'h18
`define PDM_OFF_SAMPLE_BASE 8'h40
`define PDM_CTRL_EN_BIT     0
`define PDM_CTRL_DMA_BIT    1
`define PDM_CTRL_QUAL_LSB   2
`define PDM_CTRL_RATE_LSB   8
`define PDM_CTRL_DIV_LSB    16
`define PDM_CTRL_SHIFT_LSB  24
`define PDM_ST_WMARK_BIT    0
`define PDM_ST_OVF_BIT      1
`define PDM_ST_VAD_BIT      2
`define PDM_CTRL_RST        32'h0010_2000
`define PDM_CHAN_EN_RST     8'h00
`define PDM_WMARK_RST       4'h3
`define PDM_MASK_RST        3'h0
`define PDM_VAD_THR_RST     16'h1000
`define PDM_DC_SHIFT        8
`endif

// >>> hw/pdm_pkg.sv
// Types shared by the PDM decimator
// Assumes the register header is included by the design module
package pdm_pkg;
	typedef enum logic [2:0] {
		quality_medium     = 3'h0,
		quality_high       = 3'h1,
		quality_na_2       = 3'h2,
		quality_na_3       = 3'h3,
		quality_very_low_2 = 3'h4,
		quality_very_low_1 = 3'h5,
		quality_very_low_0 = 3'h6,
		quality_low        = 3'h7
	} pdm_quality_e;
	typedef enum logic [5:0] {
		SEQ_IDLE = 6'h01,
		SEQ_COMB = 6'h02,
		SEQ_HB   = 6'h04,
		SEQ_FIR  = 6'h08,
		SEQ_DC   = 6'h10,
		SEQ_PUSH = 6'h20
	} pdm_seq_e;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pdm_wb_req_s;
	typedef struct packed {
		logic         enable;
		logic         dma_sel;
		pdm_quality_e quality;
		logic [7:0]   rate;
		logic [7:0]   div;
		logic [4:0]   shift;
	} pdm_ctrl_s;
endpackage : pdm_pkg

// >>> verification/pdm_mic_model.sv
// Behavioural PDM microphones, two on each shared data line
// Assumes one clock pin from the decimator drives every mic
`timescale 1ns/1ps
`default_nettype none
module pdm_mic_model #(
	parameter int PAIRS = 4
) (
	input  wire logic        pdm_clk_in,
	input  wire logic        rand_in,
	output logic [PAIRS-1:0] data_out
);
	initial data_out = '0;
	// Odd mic talks after the rising edge, even mic after the falling one
	always @(posedge pdm_clk_in) begin
		data_out <= rand_in ? PAIRS'($urandom) : '1;
	end
	always @(negedge pdm_clk_in) begin
		data_out <= rand_in ? PAIRS'($urandom) : '0;
	end
endmodule // pdm_mic_model
`default_nettype wire

// >>> verification/pdm_mic_decimator_sva.sv
// Checker of the decimator's bus answer, mic clock, irq and dma
// Assumes full-word writes from the master; shadows a few fields
`include "pdm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pdm_dec_sva (
	input wire logic        MCLK_IN,
	input wire logic        RST_N_IN,
	input wire logic        PDM_CLK_OUT,
	input wire logic        WB_CYC_IN,
	input wire logic        WB_STB_IN,
	input wire logic        WB_WE_IN,
	input wire logic [7:0]  WB_ADR_IN,
	input wire logic [31:0] WB_DAT_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic        WB_ACK_OUT,
	input wire logic        IRQ_OUT,
	input wire logic        DMA_REQ_OUT
);
	logic       tk, wt, unm, en, dma, msk, pq;
	logic [7:0] dv, dve, run, age;
	logic [1:0] tog;
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	assign tk  = WB_CYC_IN & WB_STB_IN & !WB_ACK_OUT;
	assign wt  = tk & WB_WE_IN;
	assign unm = (WB_ADR_IN > 8'h18 && WB_ADR_IN < 8'h40) || WB_ADR_IN > 8'h5C;
	assign dve = (dv == 8'h00) ? 8'h01 : dv;
	// Shadow of the fields the checks depend on
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			{en, dma, msk, dv} <= {3'h0, 8'h10};
		end else if (wt && WB_ADR_IN == `PDM_OFF_CTRL) begin
			{en, dma, dv} <= {WB_DAT_IN[0], WB_DAT_IN[1], WB_DAT_IN[23:16]};
		end else if (wt && WB_ADR_IN == `PDM_OFF_MASK) begin
			msk <= |WB_DAT_IN[2:0];
		end
	end
	// Age since last write, clock toggles and run length between them
	always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			{pq, run, age, tog} <= '0;
		end else begin
			pq <= PDM_CLK_OUT;
			run <= (PDM_CLK_OUT != pq) ? 8'h00 : run + {7'h0, run != 8'hFF};
			age <= wt ? 8'h00 : age + {7'h0, age != 8'hFF};
			if (wt) tog <= 2'h0;
			else if (PDM_CLK_OUT != pq && tog != 2'h2) tog <= tog + 2'h1;
		end
	end
	AST_ACK_ONE: assert property (tk |=> WB_ACK_OUT)
		else $error("bus request not answered next cycle");
	AST_ACK_PULSE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(WB_ACK_OUT) |-> $past(WB_CYC_IN & WB_STB_IN))
		else $error("ack without request");
	AST_RD_UNMAPPED: assert property (tk && !WB_WE_IN && unm |=> WB_DAT_OUT == 32'h0)
		else $error("unmapped read not zero");
	AST_CLK_OFF: assert property (!en && age > 8'h03 |-> !PDM_CLK_OUT)
		else $error("mic clock runs while disabled");
	AST_CLK_HALF: assert property ((PDM_CLK_OUT != pq) && en && tog == 2'h2
		|-> run == dve - 8'h01)
		else $error("mic clock half period wrong");
	AST_DMA_OFF: assert property (!dma && age > 8'h03 |-> !DMA_REQ_OUT)
		else $error("dma request with interrupt mode");
	AST_IRQ_MASK: assert property (!msk && age > 8'h03 |-> !IRQ_OUT)
		else $error("irq with all sources masked");
	cover property ($rose(IRQ_OUT));
	cover property ($rose(DMA_REQ_OUT));
	cover property (tk && !WB_WE_IN && unm);
endmodule // pdm_dec_sva
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench: Wishbone master, queue scoreboard, mic model
// Assumes mic clock half period of 6 cycles, CIC rate 4
`include "pdm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define PDM_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	bad_count++; $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module testbench;
	logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, mode = 0;
	logic [7:0]  adr = '0;
	logic [3:0]  sel = '0, pdm;
	logic [31:0] dat = '0, rdat, v, s, e;
	logic        pclk, ack, irq, dmar;
	logic [31:0] exp_q[$];
	string       nam_q[$], nm;
	int          bad_count = 0, compares = 0, n, k, f, m;
	pdm_mic_decimator i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n),
		.PDM_DATA_IN(pdm), .PDM_CLK_OUT(pclk), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
		.WB_DAT_IN(dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
		.IRQ_OUT(irq), .DMA_REQ_OUT(dmar));
	pdm_mic_model i_mic (.pdm_clk_in(pclk), .rand_in(mode), .data_out(pdm));
	initial forever #5 clk = ~clk;
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input string t, output logic [31:0] q);
		int c;
		@(posedge clk);
		nam_q.push_back(t);
		exp_q.push_back(d);
		{cyc, stb, we, adr, sel} <= {2'h3, w, a, 4'hF};
		dat <= w ? d : 32'h0;
		c = 0;
		do begin @(posedge clk); c++; end while (ack !== 1'b1 && c < 50);
		q = rdat;
		{cyc, stb, we} <= 3'h0;
		if (c >= 50) bad_count++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, "", q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input string t);
		logic [31:0] q;
		bus(1'b0, a, d, t, q);
	endtask
	task automatic report_and_stop();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Scoreboard: each answer is matched to the oldest note
	always @(posedge clk) begin
		if (ack === 1'b1 && nam_q.size() > 0) begin
			e = exp_q.pop_front();
			nm = nam_q.pop_front();
			if (nm != "") `PDM_CHK(nm, e, rdat)
		end
	end
	initial begin
		#400_000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		void'($urandom(72));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(`PDM_OFF_CTRL, `PDM_CTRL_RST, "ctrl");
		rd(`PDM_OFF_CHAN_EN, {24'h0, `PDM_CHAN_EN_RST}, "chan_en");
		rd(`PDM_OFF_WMARK, {28'h0, `PDM_WMARK_RST}, "wmark");
		rd(`PDM_OFF_MASK, {29'h0, `PDM_MASK_RST}, "mask");
		rd(`PDM_OFF_VAD_THR, {16'h0, `PDM_VAD_THR_RST}, "vad");
		rd(8'h24, 32'h0, "unmapped");
		for (k = 0; k < 8; k++) begin
			v = 32'h0006_0400 | (k << 2);
			wr(`PDM_OFF_CTRL, v);
			rd(`PDM_OFF_CTRL, v, "quality");
		end
		m = $urandom_range(255, 1);
		mode <= 1'($urandom);
		wr(`PDM_OFF_WMARK, 32'h2);
		wr(`PDM_OFF_MASK, 32'h1);
		wr(`PDM_OFF_CHAN_EN, m);
		wr(`PDM_OFF_CTRL, 32'h0006_0401);
		for (n = 0; n < 5000 && irq !== 1'b1; n++) @(posedge clk);
		`PDM_CHK("irq", 1'b1, irq)
		wr(`PDM_OFF_CTRL, 32'h0006_0400);
		// Enable is cleared, so no further samples land while waiting to count
		repeat (200) @(posedge clk);
		bus(1'b0, `PDM_OFF_STATUS, 32'h0, "", v);
		`PDM_CHK("wm_status", 1'b1, v[0])
		for (k = 0; k < 8; k++) begin
			bus(1'b0, `PDM_OFF_FILL, 32'h0, "", v);
			f = v[4*k+:4];
			`PDM_CHK("fill", 1'b1, m[k] ? f > 2 : f == 0)
			bus(1'b0, 8'(`PDM_OFF_SAMPLE_BASE + 4 * k), 32'h0, "", s);
			`PDM_CHK("sext", {16{s[15]}}, s[31:16])
			bus(1'b0, `PDM_OFF_FILL, 32'h0, "", v);
			`PDM_CHK("pop", 4'(m[k] ? f - 1 : 0), v[4*k+:4])
		end
		wr(`PDM_OFF_STATUS, 32'h7);
		rd(`PDM_OFF_STATUS, 32'h0, "w1c");
		`PDM_CHK("irq_clr", 1'b0, irq)
		wr(`PDM_OFF_CHAN_EN, 32'h0);
		rd(`PDM_OFF_FILL, 32'h0, "flush");
		wr(`PDM_OFF_CHAN_EN, m);
		wr(`PDM_OFF_CTRL, 32'h0006_0403);
		for (n = 0; n < 5000 && dmar !== 1'b1; n++) @(posedge clk);
		`PDM_CHK("dma", 1'b1, dmar)
		`PDM_CHK("irq_dma", 1'b0, irq)
		wr(`PDM_OFF_CTRL, 32'h0006_0400);
		repeat (10) @(posedge clk);
		report_and_stop();
	end
endmodule // testbench
bind pdm_mic_decimator pdm_dec_sva i_sva (.MCLK_IN(MCLK_IN),
	.RST_N_IN(RST_N_IN), .PDM_CLK_OUT(PDM_CLK_OUT), .WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
	.WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
	.IRQ_OUT(IRQ_OUT), .DMA_REQ_OUT(DMA_REQ_OUT));
`default_nettype wire
